// File: dv/sfc_chk.sv
// Pin-level checker for the frequency-change control block
`timescale 1ns/1ns
module sfc_chk (
    // Clock, reset, inputs
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_sen,
    input wire logic i_cal_done,
    input wire logic [7:0] i_cal_band,
    // Outputs watched
    input wire logic [23:0] o_int_div,
    input wire logic [23:0] o_frac_div,
    input wire logic [7:0] o_vco_band,
    input wire logic o_cal_start,
    input wire logic o_cal_busy,
    input wire logic [5:0] o_out_div,
    input wire logic o_mute,
    input wire logic [1:0] o_buf_dis,
    input wire logic [6:0] o_cp_up_gain
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    sequence s_cal_end;
        o_cal_busy && i_cal_done;
    endsequence
    sequence s_idle_soon;
        ##[1:3] !o_cal_busy;
    endsequence
    a_start_one_cycle: assert property (o_cal_start |=> !o_cal_start)
        else $error("start pulse longer than one cycle");
    a_start_sets_busy: assert property (o_cal_start |-> ##[0:1] o_cal_busy)
        else $error("busy missing after start");
    a_band_from_cal: assert property (s_cal_end |=> o_vco_band == $past(i_cal_band))
        else $error("band not taken from calibration");
    a_busy_clears: assert property (s_cal_end |-> s_idle_soon)
        else $error("busy stuck after calibration end");
    a_busy_holds: assert property (o_cal_busy && !i_cal_done && !$past(i_cal_done) |=> o_cal_busy)
        else $error("busy dropped early");
    a_div_wait_cal: assert property (o_cal_busy && $past(o_cal_busy) && !$past(i_cal_done)
        |-> $stable({o_int_div, o_frac_div}))
        else $error("divider loaded before calibration end");
    a_mute_div_zero: assert property (o_out_div == 6'h00 && $past(o_out_div) == 6'h00 |-> o_mute)
        else $error("output not muted with divider zero");
    a_mute_release: assert property (o_out_div != 6'h00 && $past(o_out_div) != 6'h00
        && !o_cal_busy && !$past(o_cal_busy) |-> !o_mute)
        else $error("output muted outside calibration");
    a_write_after_frame: assert property ($changed({o_cp_up_gain, o_out_div, o_buf_dis})
        |-> !$past(i_sen) && !$past(i_sen, 2))
        else $error("register changed inside a frame");
endmodule
bind sfc_freq_ctrl sfc_chk i_sfc_chk (.i_clk, .i_rst, .i_sen, .i_cal_done, .i_cal_band,
    .o_int_div, .o_frac_div, .o_vco_band, .o_cal_start, .o_cal_busy, .o_out_div, .o_mute,
    .o_buf_dis, .o_cp_up_gain);

// File: dv/sfc_freq_ctrl_bench.sv
// Self-checking bench for the frequency-change control block
`timescale 1ns/1ns
`include "sfc_params.svh"
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin fails++; \
    $display("Error %s exp %h got %h", n, e, s); end end
module sfc_freq_ctrl_bench;
    typedef struct { int id; logic [23:0] v; } sfc_note_t;
    logic i_clk = 1'b0, i_rst = 1'b1, i_cal_done = 1'b0;
    logic [7:0] i_cal_band = 8'h00, band;
    logic sck, sen, sdi, o_sdo, o_frac_mode, o_cal_start, o_cal_busy, o_mute;
    logic o_cp_ofs_up, o_cp_ofs_dn;
    logic [23:0] o_int_div, o_frac_div, rd, d, fr;
    logic [7:0] o_vco_band;
    logic [5:0] o_out_div;
    logic [4:0] o_out_gain;
    logic [1:0] o_buf_dis;
    logic [6:0] o_cp_up_gain, o_cp_dn_gain, o_cp_ofs_mag;
    int fails = 0, checks_done = 0, seed = 49923, cnt = 0, w;
    string nm[11] = '{"int", "frac", "band", "mute", "odiv", "ogain", "buf", "pump", "busy",
        "mode", "read"};
    sfc_note_t q[$];
    always #25 i_clk = ~i_clk;
    sfc_freq_ctrl i_sfc_freq_ctrl (.i_clk, .i_rst, .i_sck(sck), .i_sen(sen), .i_sdi(sdi),
        .o_sdo, .i_cal_done, .i_cal_band, .o_frac_mode, .o_int_div, .o_frac_div, .o_vco_band,
        .o_cal_start, .o_cal_busy, .o_out_div, .o_out_gain, .o_mute, .o_buf_dis,
        .o_cp_up_gain, .o_cp_dn_gain, .o_cp_ofs_mag, .o_cp_ofs_up, .o_cp_ofs_dn);
    sfc_host i_sfc_host (.i_clk, .i_sdo(o_sdo), .o_sck(sck), .o_sen(sen), .o_sdi(sdi));
    // Calibration engine stand-in, slow enough to be seen busy
    always @(posedge i_clk) begin
        i_cal_done <= (cnt == 1);
        if (o_cal_start) cnt <= 20 + {$random(seed)} % 20;
        else if (cnt > 0) cnt <= cnt - 1;
        if (o_cal_start) i_cal_band <= 8'($random(seed));
    end
    function automatic logic [23:0] obs(int id);
        case (id)
            0: return o_int_div;
            1: return o_frac_div;
            2: return {16'h0, o_vco_band};
            3: return {23'h0, o_mute};
            4: return {18'h0, o_out_div};
            5: return {19'h0, o_out_gain};
            6: return {22'h0, o_buf_dis};
            7: return {1'b0, o_cp_ofs_dn, o_cp_ofs_up, o_cp_ofs_mag, o_cp_up_gain, o_cp_dn_gain};
            8: return {23'h0, o_cal_busy};
            9: return {23'h0, o_frac_mode};
            default: return rd;
        endcase
    endfunction
    task automatic note(int id, logic [23:0] v);
        q.push_back('{id, v});
    endtask
    // Mid-cycle compare, away from the edge where outputs move
    always @(negedge i_clk) begin
        sfc_note_t n;
        while (q.size() > 0) begin
            n = q.pop_front();
            `CHK(nm[n.id], n.v, obs(n.id))
        end
    end
    task automatic give_verdict();
        if (fails == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge i_clk);
        i_rst <= 1'b0;
        repeat (4) @(posedge i_clk);
        note(3, 24'h1);
        d = 24'($random(seed));
        i_sfc_host.xfer(1'b0, `SFC_ADDR_PUMP, d, 32, rd);
        note(7, d & 24'h7FFFFF);
        i_sfc_host.xfer(1'b0, `SFC_ADDR_PUMP, ~d, 20, rd);
        note(7, d & 24'h7FFFFF);
        i_sfc_host.pump(7'h32, 7'h10, 1'b1);
        note(7, {3'b001, 7'h10, 7'h32, 7'h32});
        for (int k = 0; k < 3; k++) begin
            d = (k == 1) ? 24'h0 : 24'($random(seed)) | 24'h1;
            i_sfc_host.xfer(1'b0, `SFC_ADDR_ODIV, d, 32, rd);
            note(4, 24'(d[5:0]));
            note(5, 24'(d[10:6]));
            note(3, 24'(d[5:0] == 6'h00));
        end
        d = 24'h80 | (24'($random(seed)) & 24'h30);
        i_sfc_host.xfer(1'b0, `SFC_ADDR_OCFG, d, 32, rd);
        note(6, 24'(d[5:4]));
        i_sfc_host.xfer(1'b0, `SFC_ADDR_CAL, 24'h800, 32, rd);
        for (int k = 0; k < 2; k++) begin
            i_sfc_host.xfer(1'b0, `SFC_ADDR_MODE, k == 0 ? 24'h800 : 24'h0, 32, rd);
            note(9, 24'(k == 0));
            band = 8'($random(seed));
            d = 24'($random(seed));
            i_sfc_host.hop(1'b1, k == 0, band, d, ~d, 24'h0);
            note(2, {16'h0, band});
            note(0, d);
            if (k == 0) note(1, ~d);
            note(8, 24'h0);
        end
        i_sfc_host.xfer(1'b0, `SFC_ADDR_CAL, 24'h0, 32, rd);
        for (int k = 0; k < 4; k++) begin
            if (k % 2 == 0) begin
                i_sfc_host.xfer(1'b0, `SFC_ADDR_MODE, k == 0 ? 24'h800 : 24'h0, 32, rd);
                d = 24'($random(seed));
            end
            // Integer mode leaves the last fraction in place
            if (k < 2) fr = d;
            i_sfc_host.hop(1'b0, k < 2, 8'h00, d, d, k == 1 ? d : 24'h0);
            note(8, 24'h1);
            note(3, 24'h1);
            for (w = 0; w < 500 && o_cal_busy !== 1'b0; w++) @(posedge i_clk);
            if (w == 500) begin
                fails++;
                give_verdict();
            end
            // Mute is registered one cycle behind busy
            repeat (2) @(posedge i_clk);
            note(0, d);
            note(1, fr);
            note(2, {16'h0, i_cal_band});
            note(3, 24'h0);
            i_sfc_host.xfer(1'b1, `SFC_ADDR_TUNE, 24'h0, 32, rd);
            note(10, {15'h0, i_cal_band, 1'b0});
        end
        i_sfc_host.xfer(1'b1, 5'h1F, 24'h0, 32, rd);
        note(10, 24'h0);
        repeat (4) @(posedge i_clk);
        give_verdict();
    end
endmodule

// File: dv/sfc_host.sv
// Host model driving the serial register port
`timescale 1ns/1ns
`include "sfc_params.svh"
module sfc_host (
    // Clock and read data
    input wire logic i_clk,
    input wire logic i_sdo,
    // Serial pins
    output logic o_sck,
    output logic o_sen,
    output logic o_sdi
);
    initial begin
        o_sck = 1'b0;
        o_sen = 1'b0;
        o_sdi = 1'b0;
    end
    // Half period of six clocks leaves room for the pin synchroniser
    task automatic xfer(input logic rw, input logic [4:0] a, input logic [23:0] d,
        input int n, output logic [23:0] q);
        logic [31:0] f;
        f = {rw, a, 2'b00, d};
        q = 24'h0;
        o_sen <= 1'b1;
        for (int i = 0; i < n; i++) begin
            o_sdi <= f[31-i];
            repeat (6) @(posedge i_clk);
            if (i >= 8) q = {q[22:0], i_sdo};
            o_sck <= 1'b1;
            repeat (6) @(posedge i_clk);
            o_sck <= 1'b0;
        end
        repeat (6) @(posedge i_clk);
        o_sen <= 1'b0;
        // Released data line must not keep its last level
        o_sdi <= ~o_sdi;
        repeat (8) @(posedge i_clk);
    endtask
    task automatic hop(input logic man, input logic frac, input logic [7:0] b,
        input logic [23:0] ni, input logic [23:0] nf, input logic [23:0] cur);
        logic [23:0] q;
        if (man) xfer(1'b0, `SFC_ADDR_TUNE, {15'h0, b, 1'b0}, 32, q);
        if (!frac || ni != cur) xfer(1'b0, `SFC_ADDR_INT, ni, 32, q);
        if (frac) xfer(1'b0, `SFC_ADDR_FRAC, nf, 32, q);
    endtask
    task automatic pump(input logic [6:0] g, input logic [6:0] m, input logic frac);
        logic [23:0] q;
        xfer(1'b0, `SFC_ADDR_PUMP, {1'b0, frac, frac ? m : 7'h00, g, g}, 32, q);
    endtask
endmodule

// File: rtl/sfc_freq_ctrl.sv
// Serial register port and frequency-change sequencing of the synthesizer
`timescale 1ns/1ns
`include "sfc_params.svh"
module sfc_freq_ctrl
    import sfc_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Serial port pins
    input wire logic i_sck,
    input wire logic i_sen,
    input wire logic i_sdi,
    output logic o_sdo,
    // Calibration engine result
    input wire logic i_cal_done,
    input wire logic [7:0] i_cal_band,
    // Analog controls
    output logic o_frac_mode,
    output logic [23:0] o_int_div,
    output logic [23:0] o_frac_div,
    output logic [7:0] o_vco_band,
    output logic o_cal_start,
    output logic o_cal_busy,
    output logic [5:0] o_out_div,
    output logic [4:0] o_out_gain,
    output logic o_mute,
    output logic [1:0] o_buf_dis,
    output logic [6:0] o_cp_up_gain,
    output logic [6:0] o_cp_dn_gain,
    output logic [6:0] o_cp_ofs_mag,
    output logic o_cp_ofs_up,
    output logic o_cp_ofs_dn
);
    // Pin synchronisers
    logic [1:0] sck_s_q, sen_s_q, sdi_s_q;
    logic sck_prev_q;
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            sck_s_q <= 2'b00;
            sen_s_q <= 2'b00;
            sdi_s_q <= 2'b00;
            sck_prev_q <= 1'b0;
        end else begin
            sck_s_q <= {sck_s_q[0], i_sck};
            sen_s_q <= {sen_s_q[0], i_sen};
            sdi_s_q <= {sdi_s_q[0], i_sdi};
            sck_prev_q <= sck_s_q[1];
        end
    end
    logic sck_rise, sck_fall, sen_on;
    assign sck_rise = sck_s_q[1] & ~sck_prev_q;
    assign sck_fall = ~sck_s_q[1] & sck_prev_q;
    assign sen_on = sen_s_q[1];

    // Frame: read bit, 5-bit address, 2 pad, 24 data
    logic [31:0] sh_q;
    logic [5:0] cnt_q;
    logic wr_stb;
    logic [4:0] wr_addr;
    logic [23:0] wr_data;
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            sh_q <= 32'h0000_0000;
            cnt_q <= 6'h00;
        end else if (!sen_on) begin
            cnt_q <= 6'h00;
        end else if (sck_rise && cnt_q != 6'(`SFC_FRAME_BITS)) begin
            sh_q <= {sh_q[30:0], sdi_s_q[1]};
            cnt_q <= cnt_q + 6'h01;
        end
    end
    // Only a full frame closed by enable drop writes anything
    logic sen_prev_q;
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            sen_prev_q <= 1'b0;
        end else begin
            sen_prev_q <= sen_on;
        end
    end
    assign wr_stb = sen_prev_q & ~sen_on & (cnt_q == 6'(`SFC_FRAME_BITS)) & ~sh_q[31];
    assign wr_addr = sh_q[30:26];
    assign wr_data = sh_q[23:0];

    // Register file
    logic [23:0] int_q, frac_q, mode_q, pump_q, calcfg_q;
    logic [15:0] tune_q, odiv_q, ocfg_q;
    logic cal_dis;
    assign cal_dis = calcfg_q[`SFC_CAL_DIS_BIT];
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            int_q <= 24'h000000;
            frac_q <= 24'h000000;
            mode_q <= 24'h000000;
            pump_q <= 24'h000000;
            calcfg_q <= 24'h000000;
            odiv_q <= 16'h0000;
            ocfg_q <= 16'h0000;
        end else if (wr_stb) begin
            unique case (wr_addr)
                `SFC_ADDR_INT: int_q <= wr_data;
                `SFC_ADDR_FRAC: frac_q <= wr_data;
                `SFC_ADDR_MODE: mode_q <= wr_data;
                `SFC_ADDR_PUMP: pump_q <= wr_data;
                `SFC_ADDR_CAL: calcfg_q <= wr_data;
                `SFC_ADDR_ODIV: odiv_q <= wr_data[15:0];
                `SFC_ADDR_OCFG: ocfg_q <= wr_data[15:0];
                default: ;
            endcase
        end
    end
    // Sequencer state, declared here because the tuning register reads it
    sfc_state_t state_q;
    // Band tuning: host writes, calibration overwrites the band field
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            tune_q <= 16'h0000;
        end else if (state_q == SFC_CAL && i_cal_done) begin
            tune_q[`SFC_TUNE_HI:`SFC_TUNE_LO] <= i_cal_band;
        end else if (wr_stb && wr_addr == `SFC_ADDR_TUNE) begin
            tune_q <= wr_data[15:0];
        end
    end
    // Band applied straight from the register, so a manual write acts at once
    assign o_vco_band = tune_q[`SFC_TUNE_HI:`SFC_TUNE_LO];

    // Frequency-change sequencer
    sfc_target_t tgt_q;
    logic freq_wr, wr_is_frac;
    assign o_frac_mode = mode_q[`SFC_MODE_FRAC_BIT];
    assign wr_is_frac = wr_addr == `SFC_ADDR_FRAC;
    // Fraction write changes frequency in fractional mode, integer write in integer mode
    assign freq_wr = wr_stb && (o_frac_mode ? wr_is_frac : (wr_addr == `SFC_ADDR_INT));
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state_q <= SFC_IDLE;
            tgt_q <= SFC_TGT_INT;
        end else begin
            unique case (state_q)
                SFC_IDLE: begin
                    // Same-value rewrite still calibrates
                    if (freq_wr && !cal_dis) begin
                        state_q <= SFC_CAL;
                        tgt_q <= wr_is_frac ? SFC_TGT_FRAC : SFC_TGT_INT;
                    end
                end
                SFC_CAL: begin
                    if (i_cal_done) begin
                        state_q <= SFC_LOAD;
                    end
                end
                SFC_LOAD: state_q <= SFC_IDLE;
                default: state_q <= SFC_IDLE;
            endcase
        end
    end
    // Calibration start pulse; engine holds measurement timing itself
    logic start_q;
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            start_q <= 1'b0;
        end else begin
            start_q <= state_q == SFC_IDLE && freq_wr && !cal_dis;
        end
    end
    assign o_cal_start = start_q;
    assign o_cal_busy = state_q != SFC_IDLE;

    // Divider values applied to the loop
    logic [23:0] int_app_q, frac_app_q;
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            int_app_q <= 24'h000000;
            frac_app_q <= 24'h000000;
        end else begin
            if (state_q == SFC_LOAD) begin
                // Both halves load together after calibration
                int_app_q <= int_q;
                frac_app_q <= frac_q;
            end else if (state_q == SFC_IDLE && wr_stb && cal_dis) begin
                if (wr_addr == `SFC_ADDR_INT) begin
                    int_app_q <= wr_data;
                end
                if (wr_is_frac) begin
                    frac_app_q <= wr_data;
                end
            end else if (state_q == SFC_IDLE && wr_stb && o_frac_mode
                         && wr_addr == `SFC_ADDR_INT) begin
                // Integer waits for the fraction write in fractional mode
                int_app_q <= int_app_q;
            end
        end
    end
    assign o_int_div = int_app_q;
    assign o_frac_div = frac_app_q;

    // Output stage and pump fields
    assign o_out_div = odiv_q[`SFC_ODIV_HI:`SFC_ODIV_LO];
    assign o_out_gain = odiv_q[`SFC_OGAIN_HI:`SFC_OGAIN_LO];
    logic mute_q;
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            mute_q <= 1'b1;
        end else begin
            mute_q <= (o_out_div == 6'h00)
                || (ocfg_q[`SFC_AUTOMUTE_BIT] && state_q != SFC_IDLE);
        end
    end
    assign o_mute = mute_q;
    assign o_buf_dis = ocfg_q[`SFC_BUF_HI:`SFC_BUF_LO];
    assign o_cp_up_gain = pump_q[`SFC_UPG_HI:`SFC_UPG_LO];
    assign o_cp_dn_gain = pump_q[`SFC_DNG_HI:`SFC_DNG_LO];
    assign o_cp_ofs_mag = pump_q[`SFC_OFS_HI:`SFC_OFS_LO];
    assign o_cp_ofs_up = pump_q[`SFC_OFS_UP_BIT];
    assign o_cp_ofs_dn = pump_q[`SFC_OFS_DN_BIT];

    // Readback: read frame shifts data out on falling clock after address
    function automatic logic [23:0] rd_mux(input logic [4:0] a);
        unique case (a)
            `SFC_ADDR_INT: rd_mux = int_q;
            `SFC_ADDR_FRAC: rd_mux = frac_q;
            `SFC_ADDR_MODE: rd_mux = mode_q;
            `SFC_ADDR_PUMP: rd_mux = pump_q;
            `SFC_ADDR_CAL: rd_mux = calcfg_q;
            `SFC_ADDR_TUNE: rd_mux = {8'h00, tune_q};
            `SFC_ADDR_ODIV: rd_mux = {8'h00, odiv_q};
            `SFC_ADDR_OCFG: rd_mux = {8'h00, ocfg_q};
            default: rd_mux = 24'h000000;
        endcase
    endfunction
    logic [23:0] rd_q;
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rd_q <= 24'h000000;
        end else if (!sen_on) begin
            rd_q <= 24'h000000;
        end else if (sck_fall && cnt_q == 6'h08 && sh_q[7]) begin
            rd_q <= rd_mux(sh_q[6:2]);
        end else if (sck_fall && cnt_q > 6'h08) begin
            rd_q <= {rd_q[22:0], 1'b0};
        end
    end
    assign o_sdo = rd_q[23];
endmodule

// File: rtl/sfc_params.svh
// Register offsets, field positions and timing counts for the frequency-change control block
// What this block does
// - After each calibration, the chosen band setting reads back at tuning bits 8 to 1.
// - With calibration disabled, band-switch writes take effect at once.
// - Mode bit 11 set selects fractional mode, clear selects integer mode.
// - Output divider from bits 5 to 0, output gain from bits 10 to 6.
// - Fractional mode, calibration enabled: fraction write starts calibration, fraction loads after it ends.
// - Calibration disabled: fraction write loads modulator at once, band switches untouched.
// - Integer mode, calibration enabled: integer write calibrates, then loads prescaler.
// - Integer mode, calibration disabled: integer write loads prescaler at once.
// - Output divider field of zero keeps the output muted until a nonzero divider is written.
// - Auto-mute bit 7 set mutes output from one cycle after busy rises until one cycle after busy falls.
// - Output buffers disabled by configuration bits 5 and 4, apart from mute.
// - Pump up gain from bits 13 to 7, down gain from bits 6 to 0.
// - Offset magnitude bits 20 to 14; bit 21 up offset, bit 22 down offset.
// - Rewriting frequency with same value reruns calibration, same final frequency.
`ifndef SFC_PARAMS_SVH
`define SFC_PARAMS_SVH
`define SFC_ADDR_INT 5'h03
`define SFC_ADDR_FRAC 5'h04
`define SFC_ADDR_MODE 5'h06
`define SFC_ADDR_PUMP 5'h09
`define SFC_ADDR_CAL 5'h0A
`define SFC_ADDR_TUNE 5'h15
`define SFC_ADDR_ODIV 5'h16
`define SFC_ADDR_OCFG 5'h17
`define SFC_MODE_FRAC_BIT 11
`define SFC_CAL_DIS_BIT 11
`define SFC_CAL_TIME_LO 0
`define SFC_CAL_TIME_HI 2
`define SFC_TUNE_LO 1
`define SFC_TUNE_HI 8
`define SFC_ODIV_LO 0
`define SFC_ODIV_HI 5
`define SFC_OGAIN_LO 6
`define SFC_OGAIN_HI 10
`define SFC_AUTOMUTE_BIT 7
`define SFC_BUF_LO 4
`define SFC_BUF_HI 5
`define SFC_UPG_LO 7
`define SFC_UPG_HI 13
`define SFC_DNG_LO 0
`define SFC_DNG_HI 6
`define SFC_OFS_LO 14
`define SFC_OFS_HI 20
`define SFC_OFS_UP_BIT 21
`define SFC_OFS_DN_BIT 22
`define SFC_FRAME_BITS 32
`define SFC_CAL_BASE_NS 1000
`define SFC_CLK_NS 50
`define SFC_CAL_BASE_CYC ((`SFC_CAL_BASE_NS + `SFC_CLK_NS - 1) / `SFC_CLK_NS)
`endif

// File: rtl/sfc_pkg.sv
// Types for the frequency-change control block
package sfc_pkg;
    typedef enum logic [1:0] {
        SFC_IDLE = 2'b00,
        SFC_CAL = 2'b01,
        SFC_LOAD = 2'b11
    } sfc_state_t;
    typedef enum logic {
        SFC_TGT_INT = 1'b0,
        SFC_TGT_FRAC = 1'b1
    } sfc_target_t;
endpackage
